/* design/cfrsp_pkg.sv */
// Shared constants and types for the CPU flag register, working registers and stack pointer.
// Assumes a single core clock and an external decoder that drives one operation per cycle.
package cfrsp_pkg;

   // Working register file geometry.
   localparam int NUM_REGS = 32;
   localparam int REG_AW   = 5;
   localparam int DATA_W   = 8;

   // Bit positions inside the flag register.
   localparam int FLAG_I = 7;
   localparam int FLAG_T = 6;
   localparam int FLAG_H = 5;
   localparam int FLAG_S = 4;
   localparam int FLAG_V = 3;
   localparam int FLAG_N = 2;
   localparam int FLAG_Z = 1;
   localparam int FLAG_C = 0;

   // Flags that an ALU operation may touch; I and T are never changed by the ALU.
   localparam logic [7:0] ALU_FLAG_MASK = 8'h3f;

   // I/O addresses of the architectural registers.
   localparam logic [5:0] IO_SP_LOW  = 6'h3d;
   localparam logic [5:0] IO_SP_HIGH = 6'h3e;
   localparam logic [5:0] IO_FLAGS   = 6'h3f;

   // Reset values.
   localparam logic [7:0]  FLAGS_RESET = 8'h00;
   localparam logic [15:0] TOP_OF_DATA_MEMORY = 16'hffff;

   // First data-space address above the working registers.
   localparam logic [15:0] DS_REG_END = 16'h0020;

   // Low register of each pointer pair.
   localparam int PAIR_X = 26;
   localparam int PAIR_Y = 28;
   localparam int PAIR_Z = 30;

   // Operations on the flag register requested by the decoder.
   typedef enum logic [2:0] {
      FOP_NONE,
      FOP_ALU,
      FOP_SEI,
      FOP_CLI,
      FOP_RETURN_FROM_INTERRUPT,
      FOP_BST,
      FOP_BLD
   } cfrsp_flag_op_t;

   // Stack pointer adjustments.
   typedef enum logic [2:0] {
      SP_HOLD,
      SP_PUSH1,
      SP_PUSH2,
      SP_POP1,
      SP_POP2
   } cfrsp_sp_op_t;

   // Pointer addressing modes.
   typedef enum logic [2:0] {
      PTR_NONE,
      PTR_PLAIN,
      PTR_DISP,
      PTR_POSTINC,
      PTR_PREDEC
   } cfrsp_ptr_op_t;

   // Pointer pair selection.
   typedef enum logic [1:0] {
      PSEL_X,
      PSEL_Y,
      PSEL_Z
   } cfrsp_ptr_sel_t;

endpackage

/* design/cfrsp_regmem.sv */
// Storage of the working registers with three registered read ports and two byte write ports.
// Assumes the caller never writes the same address on both write ports in one cycle.
`timescale 1ns/1ps
`default_nettype none
module cfrsp_regmem #(
   parameter int DEPTH = cfrsp_pkg::NUM_REGS
) (
   input  wire logic                          clk_sys,
   input  wire logic                          rst_b,
   input  wire logic                          we0,
   input  wire logic [cfrsp_pkg::REG_AW-1:0]  wa0,
   input  wire logic [cfrsp_pkg::DATA_W-1:0]  wd0,
   input  wire logic                          we1,
   input  wire logic [cfrsp_pkg::REG_AW-1:0]  wa1,
   input  wire logic [cfrsp_pkg::DATA_W-1:0]  wd1,
   input  wire logic [cfrsp_pkg::REG_AW-1:0]  ra_a,
   input  wire logic [cfrsp_pkg::REG_AW-1:0]  ra_b,
   input  wire logic [cfrsp_pkg::REG_AW-1:0]  ra_c,
   output logic      [cfrsp_pkg::DATA_W-1:0]  rd_a_q,
   output logic      [cfrsp_pkg::DATA_W-1:0]  rd_b_q,
   output logic      [cfrsp_pkg::DATA_W-1:0]  rd_c_q,
   output logic      [2:0][15:0]              ptr_pairs
);
   import cfrsp_pkg::*;

   logic [DATA_W-1:0] mem_q [DEPTH];
   logic [DATA_W-1:0] rd_a_d;
   logic [DATA_W-1:0] rd_b_d;
   logic [DATA_W-1:0] rd_c_d;

   // Each entry takes the byte addressed to it on either write port.
   for (genvar g = 0; g < DEPTH; g++) begin : g_entry
      logic [DATA_W-1:0] ent_d;
      always_comb begin
         ent_d = mem_q[g];
         if (we0 && wa0 == REG_AW'(g)) begin
            ent_d = wd0;
         end
         if (we1 && wa1 == REG_AW'(g)) begin
            ent_d = wd1;
         end
      end
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            mem_q[g] <= '0;
         end else begin
            mem_q[g] <= ent_d;
         end
      end
   end

   // A read of a byte written in the same cycle returns the new byte.
   function automatic logic [DATA_W-1:0] rd_byp(input logic [REG_AW-1:0] a);
      logic [DATA_W-1:0] v;
      v = mem_q[a];
      if (we0 && wa0 == a) begin
         v = wd0;
      end
      if (we1 && wa1 == a) begin
         v = wd1;
      end
      return v;
   endfunction

   // Next values of the read registers.
   always_comb begin
      rd_a_d = rd_byp(ra_a);
      rd_b_d = rd_byp(ra_b);
      rd_c_d = rd_byp(ra_c);
   end

   // Read data registers.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_a_q <= '0;
         rd_b_q <= '0;
         rd_c_q <= '0;
      end else begin
         rd_a_q <= rd_a_d;
         rd_b_q <= rd_b_d;
         rd_c_q <= rd_c_d;
      end
   end

   // The upper six registers seen as three little-endian 16-bit pointers.
   assign ptr_pairs[0] = {mem_q[PAIR_X + 1], mem_q[PAIR_X]};
   assign ptr_pairs[1] = {mem_q[PAIR_Y + 1], mem_q[PAIR_Y]};
   assign ptr_pairs[2] = {mem_q[PAIR_Z + 1], mem_q[PAIR_Z]};

endmodule
`default_nettype wire

/* design/cfrsp_flagcalc.sv */
// Combinational merge of ALU outcome into the flag byte.
// Assumes the ALU supplies carry, half carry and overflow; zero and negative are derived here.
`timescale 1ns/1ps
`default_nettype none
module cfrsp_flagcalc (
   input  wire logic [7:0]  flags_old,
   input  wire logic [15:0] alu_res,
   input  wire logic        alu_wide,
   input  wire logic        alu_c,
   input  wire logic        alu_h,
   input  wire logic        alu_v,
   input  wire logic [7:0]  alu_mask,
   output logic      [7:0]  flags_new
);
   import cfrsp_pkg::*;

   logic [7:0] cand;
   logic [7:0] eff_mask;
   logic       neg;
   logic       zero;

   // Candidate flags from the result, merged under the per-operation mask.
   always_comb begin
      zero           = alu_wide ? (alu_res == 16'h0000) : (alu_res[7:0] == 8'h00);
      neg            = alu_wide ? alu_res[15] : alu_res[7];
      cand           = flags_old;
      cand[FLAG_C]   = alu_c;
      cand[FLAG_Z]   = zero;
      cand[FLAG_N]   = neg;
      cand[FLAG_V]   = alu_v;
      cand[FLAG_H]   = alu_h;
      eff_mask       = alu_mask & ALU_FLAG_MASK;
      flags_new      = (flags_old & ~eff_mask) | (cand & eff_mask);
      flags_new[FLAG_S] = flags_new[FLAG_N] ^ flags_new[FLAG_V];
   end

endmodule
`default_nettype wire

/* design/cfrsp_top.sv */
// Flag register, working register file, pointer pairs and stack pointer of the core.
// Assumes the decoder drives operand addresses one cycle ahead of the ALU result.
`timescale 1ns/1ps
`default_nettype none
module cfrsp_top #(
   parameter logic [15:0] SP_RESET   = cfrsp_pkg::TOP_OF_DATA_MEMORY,
   parameter int          PTR_DISP_W = 6
) (
   input  wire logic                          clk_sys,
   input  wire logic                          rst_b,
   input  wire logic [cfrsp_pkg::REG_AW-1:0]  rd_a_addr,
   input  wire logic [cfrsp_pkg::REG_AW-1:0]  rd_b_addr,
   input  wire logic                          rd_wide,
   output logic      [cfrsp_pkg::DATA_W-1:0]  rd_a_data_q,
   output logic      [cfrsp_pkg::DATA_W-1:0]  rd_b_data_q,
   input  wire logic                          wr_en,
   input  wire logic                          wr_wide,
   input  wire logic [cfrsp_pkg::REG_AW-1:0]  wr_addr,
   input  wire logic [15:0]                   wr_data,
   input  wire cfrsp_pkg::cfrsp_flag_op_t     flag_op,
   input  wire logic [15:0]                   alu_res,
   input  wire logic                          alu_wide,
   input  wire logic                          alu_c,
   input  wire logic                          alu_h,
   input  wire logic                          alu_v,
   input  wire logic [7:0]                    alu_mask,
   input  wire logic [2:0]                    bit_sel,
   output logic      [7:0]                    flag_q,
   input  wire logic                          irq_req,
   output logic                               irq_grant_q,
   input  wire cfrsp_pkg::cfrsp_sp_op_t       sp_op,
   output logic      [15:0]                   sp_q,
   input  wire cfrsp_pkg::cfrsp_ptr_op_t      ptr_op,
   input  wire cfrsp_pkg::cfrsp_ptr_sel_t     ptr_sel,
   input  wire logic [PTR_DISP_W-1:0]         ptr_disp,
   output logic      [15:0]                   ptr_addr_q,
   input  wire logic                          ds_req,
   input  wire logic                          ds_we,
   input  wire logic [15:0]                   ds_addr,
   input  wire logic [cfrsp_pkg::DATA_W-1:0]  ds_wdata,
   output logic      [cfrsp_pkg::DATA_W-1:0]  ds_rdata_q,
   output logic                               ds_hit_q,
   input  wire logic                          io_req,
   input  wire logic                          io_we,
   input  wire logic [5:0]                    io_addr,
   input  wire logic [7:0]                    io_wdata,
   output logic      [7:0]                    io_rdata_q,
   output logic                               io_hit_q
);
   import cfrsp_pkg::*;

   // The whole block runs on clk_sys as delivered; there is no divider.

   logic              we0;
   logic [REG_AW-1:0] wa0;
   logic [DATA_W-1:0] wd0;
   logic              we1;
   logic [REG_AW-1:0] wa1;
   logic [DATA_W-1:0] wd1;
   logic [REG_AW-1:0] ra_a;
   logic [REG_AW-1:0] ra_b;
   logic [2:0][15:0]  ptr_pairs;
   logic [7:0]        alu_flags;
   logic [7:0]        flag_d;
   logic              irq_grant_d;
   logic [15:0]       sp_d;
   logic [15:0]       ptr_cur;
   logic [REG_AW-1:0] ptr_base;
   logic [15:0]       ptr_eff;
   logic [15:0]       ptr_upd;
   logic              ptr_wb;
   logic [15:0]       ptr_addr_d;
   logic              ds_in_regs;
   logic              ds_hit_d;
   logic [7:0]        io_rdata_d;
   logic              io_hit_d;
   logic [DATA_W-1:0] bld_byte;

   // Register storage; a 16-bit read takes an aligned pair on ports a and b.
   always_comb begin
      ra_a = rd_a_addr;
      ra_b = rd_b_addr;
      if (rd_wide) begin
         ra_a = {rd_a_addr[REG_AW-1:1], 1'b0};
         ra_b = {rd_a_addr[REG_AW-1:1], 1'b1};
      end
   end

   cfrsp_regmem #(
      .DEPTH (NUM_REGS)
   ) u_regmem (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .we0       (we0),
      .wa0       (wa0),
      .wd0       (wd0),
      .we1       (we1),
      .wa1       (wa1),
      .wd1       (wd1),
      .ra_a      (ra_a),
      .ra_b      (ra_b),
      .ra_c      (ds_addr[REG_AW-1:0]),
      .rd_a_q    (rd_a_data_q),
      .rd_b_q    (rd_b_data_q),
      .rd_c_q    (ds_rdata_q),
      .ptr_pairs (ptr_pairs)
   );

   // Flag candidates from the ALU outcome.
   cfrsp_flagcalc u_flagcalc (
      .flags_old (flag_q),
      .alu_res   (alu_res),
      .alu_wide  (alu_wide),
      .alu_c     (alu_c),
      .alu_h     (alu_h),
      .alu_v     (alu_v),
      .alu_mask  (alu_mask),
      .flags_new (alu_flags)
   );

   // Pointer selection and the effective address of each addressing mode.
   always_comb begin
      ptr_cur  = '0;
      ptr_base = REG_AW'(PAIR_Z);
      unique case (ptr_sel)
         PSEL_X: begin
            ptr_cur  = ptr_pairs[0];
            ptr_base = REG_AW'(PAIR_X);
         end
         PSEL_Y: begin
            ptr_cur  = ptr_pairs[1];
            ptr_base = REG_AW'(PAIR_Y);
         end
         PSEL_Z: begin
            ptr_cur  = ptr_pairs[2];
            ptr_base = REG_AW'(PAIR_Z);
         end
         default: begin
            ptr_cur  = '0;
            ptr_base = REG_AW'(PAIR_Z);
         end
      endcase
      ptr_eff = ptr_cur;
      ptr_upd = ptr_cur;
      ptr_wb  = 1'b0;
      unique case (ptr_op)
         PTR_NONE: begin
            ptr_eff = ptr_addr_q;
         end
         PTR_PLAIN: begin
            ptr_eff = ptr_cur;
         end
         PTR_DISP: begin
            ptr_eff = ptr_cur + 16'(ptr_disp);
         end
         PTR_POSTINC: begin
            ptr_upd = ptr_cur + 16'h0001;
            ptr_wb  = 1'b1;
         end
         PTR_PREDEC: begin
            ptr_eff = ptr_cur - 16'h0001;
            ptr_upd = ptr_eff;
            ptr_wb  = 1'b1;
         end
         default: begin
            ptr_eff = ptr_addr_q;
         end
      endcase
      ptr_addr_d = ptr_eff;
   end

   // The bit load result: operand a with the chosen bit replaced by T.
   always_comb begin
      bld_byte          = rd_a_data_q;
      bld_byte[bit_sel] = flag_q[FLAG_T];
   end

   // Write port steering: ALU result first, then bit load, pointer update, data-space store.
   always_comb begin
      ds_in_regs = ds_addr < DS_REG_END;
      we0 = 1'b0;
      wa0 = '0;
      wd0 = '0;
      we1 = 1'b0;
      wa1 = '0;
      wd1 = '0;
      if (wr_en) begin
         we0 = 1'b1;
         wa0 = wr_wide ? {wr_addr[REG_AW-1:1], 1'b0} : wr_addr;
         wd0 = wr_data[7:0];
         if (wr_wide) begin
            we1 = 1'b1;
            wa1 = {wr_addr[REG_AW-1:1], 1'b1};
            wd1 = wr_data[15:8];
         end
      end else if (flag_op == FOP_BLD) begin
         we0 = 1'b1;
         wa0 = wr_addr;
         wd0 = bld_byte;
      end else if (ptr_wb) begin
         we0 = 1'b1;
         wa0 = ptr_base;
         wd0 = ptr_upd[7:0];
         we1 = 1'b1;
         wa1 = ptr_base + 5'h01;
         wd1 = ptr_upd[15:8];
      end else if (ds_req && ds_we && ds_in_regs) begin
         we0 = 1'b1;
         wa0 = ds_addr[REG_AW-1:0];
         wd0 = ds_wdata;
      end
      ds_hit_d = ds_req && ds_in_regs;
   end

   // Interrupt grant: only while global enable is set and no CLI is requested in the same cycle.
   always_comb begin
      irq_grant_d = irq_req && flag_q[FLAG_I] && !irq_grant_q
                    && (flag_op != FOP_CLI);
   end

   // Next flag value. Interrupt entry and return leave all other flags alone.
   always_comb begin
      flag_d = flag_q;
      unique case (flag_op)
         FOP_NONE: begin
            flag_d = flag_q;
         end
         FOP_ALU: begin
            flag_d = alu_flags;
         end
         FOP_SEI: begin
            flag_d[FLAG_I] = 1'b1;
         end
         FOP_CLI: begin
            flag_d[FLAG_I] = 1'b0;
         end
         FOP_RETURN_FROM_INTERRUPT: begin
            flag_d[FLAG_I] = 1'b1;
         end
         FOP_BST: begin
            flag_d[FLAG_T] = rd_a_data_q[bit_sel];
         end
         FOP_BLD: begin
            flag_d = flag_q;
         end
         default: begin
            flag_d = flag_q;
         end
      endcase
      if (irq_grant_d && flag_op != FOP_RETURN_FROM_INTERRUPT) begin
         flag_d[FLAG_I] = 1'b0;
      end
      if (io_req && io_we && io_addr == IO_FLAGS) begin
         flag_d = io_wdata;
      end
      flag_d[FLAG_S] = flag_d[FLAG_N] ^ flag_d[FLAG_V];
   end

   // Stack pointer: an I/O write replaces its own byte of the push or pop result in the same cycle.
   always_comb begin
      sp_d = sp_q;
      unique case (sp_op)
         SP_HOLD: begin
            sp_d = sp_q;
         end
         SP_PUSH1: begin
            sp_d = sp_q - 16'h0001;
         end
         SP_PUSH2: begin
            sp_d = sp_q - 16'h0002;
         end
         SP_POP1: begin
            sp_d = sp_q + 16'h0001;
         end
         SP_POP2: begin
            sp_d = sp_q + 16'h0002;
         end
         default: begin
            sp_d = sp_q;
         end
      endcase
      if (io_req && io_we && io_addr == IO_SP_LOW) begin
         sp_d[7:0] = io_wdata;
      end
      if (io_req && io_we && io_addr == IO_SP_HIGH) begin
         sp_d[15:8] = io_wdata;
      end
   end

   // I/O read data; unmapped addresses read zero and report no hit.
   always_comb begin
      io_rdata_d = 8'h00;
      io_hit_d   = 1'b0;
      if (io_req) begin
         unique case (io_addr)
            IO_SP_LOW: begin
               io_rdata_d = sp_q[7:0];
               io_hit_d   = 1'b1;
            end
            IO_SP_HIGH: begin
               io_rdata_d = sp_q[15:8];
               io_hit_d   = 1'b1;
            end
            IO_FLAGS: begin
               io_rdata_d = flag_q;
               io_hit_d   = 1'b1;
            end
            default: begin
               io_rdata_d = 8'h00;
               io_hit_d   = 1'b0;
            end
         endcase
      end
   end

   // Architectural state and registered outputs.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         flag_q      <= FLAGS_RESET;
         sp_q        <= SP_RESET;
         irq_grant_q <= 1'b0;
         ptr_addr_q  <= '0;
         ds_hit_q    <= 1'b0;
         io_rdata_q  <= 8'h00;
         io_hit_q    <= 1'b0;
      end else begin
         flag_q      <= flag_d;
         sp_q        <= sp_d;
         irq_grant_q <= irq_grant_d;
         ptr_addr_q  <= ptr_addr_d;
         ds_hit_q    <= ds_hit_d;
         io_rdata_q  <= io_rdata_d;
         io_hit_q    <= io_hit_d;
      end
   end

endmodule
`default_nettype wire

/* test/cfrsp_top_assertions.sv */
// Checker of the flag, interrupt and stack pointer ports of the register block.
// Assumes one core clock with an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module cfrsp_top_assertions (
   input wire logic                      clk_sys,
   input wire logic                      rst_b,
   input wire cfrsp_pkg::cfrsp_flag_op_t flag_op,
   input wire logic [15:0]               alu_res,
   input wire logic                      alu_wide,
   input wire logic [7:0]                alu_mask,
   input wire logic [7:0]                flag_q,
   input wire logic                      irq_req,
   input wire logic                      irq_grant_q,
   input wire cfrsp_pkg::cfrsp_sp_op_t   sp_op,
   input wire logic [15:0]               sp_q,
   input wire logic                      io_req
);
   import cfrsp_pkg::*;
   // Cycles with no I/O access and no pending interrupt.
   wire quiet = !io_req && !irq_req;
   // All checks use the core clock and rest while reset is low.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   // A taken interrupt gives one grant pulse with the enable already cleared.
   sequence s_taken;
      irq_grant_q && !flag_q[FLAG_I] ##1 !irq_grant_q;
   endsequence
   AST_TAKEN_CLEARS_I: assert property (
      irq_req && flag_q[FLAG_I] && !irq_grant_q && flag_op == FOP_NONE && !io_req |=> s_taken)
      else $error("taken interrupt kept enable");
   AST_CLI_BLOCKS: assert property (
      flag_op == FOP_CLI && !io_req |=> !flag_q[FLAG_I] && !irq_grant_q) else $error("clear failed");
   AST_NO_GRANT_OFF: assert property (
      !flag_q[FLAG_I] |=> !irq_grant_q) else $error("grant while disabled");
   AST_RETURN_FROM_INTERRUPT_SETS: assert property (
      flag_op == FOP_RETURN_FROM_INTERRUPT && !io_req |=> flag_q[FLAG_I]) else $error("return left enable clear");
   AST_SEI_SETS: assert property (
      flag_op == FOP_SEI && quiet |=> flag_q[FLAG_I]) else $error("set failed");
   AST_SIGN: assert property (
      flag_q[FLAG_S] == (flag_q[FLAG_N] ^ flag_q[FLAG_V])) else $error("sign bit wrong");
   AST_ZERO: assert property (
      flag_op == FOP_ALU && !alu_wide && alu_mask[FLAG_Z] && !io_req
      |=> flag_q[FLAG_Z] == (($past(alu_res) & 16'h00ff) == 16'h0000)) else $error("zero flag wrong");
   AST_PUSH1: assert property (
      sp_op == SP_PUSH1 && !io_req |=> sp_q == $past(sp_q) - 16'h0001) else $error("push1 wrong");
   AST_PUSH2: assert property (
      sp_op == SP_PUSH2 && !io_req |=> sp_q == $past(sp_q) - 16'h0002) else $error("push2 wrong");
   AST_POP: assert property (
      sp_op inside {SP_POP1, SP_POP2} && !io_req
      |=> sp_q - $past(sp_q) == (($past(sp_op) == SP_POP2) ? 16'h0002 : 16'h0001)) else $error("pop wrong");
endmodule
bind cfrsp_top cfrsp_top_assertions cfrsp_top_assertions_inst (.clk_sys, .rst_b, .flag_op, .alu_res,
   .alu_wide, .alu_mask, .flag_q, .irq_req, .irq_grant_q, .sp_op, .sp_q, .io_req);
`default_nettype wire

/* test/cfrsp_alu_model.sv */
// Behavioural adder standing in for the core's ALU at the operand ports.
// Assumes operands come from the registered read ports and the sum is taken in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module cfrsp_alu_model (
   input  wire logic [7:0]  op_a,
   input  wire logic [7:0]  op_b,
   output logic      [15:0] sum,
   output logic             carry,
   output logic             half,
   output logic             ovf
);
   logic [8:0] full;
   // Eight-bit add with carry, half carry and signed overflow.
   always_comb begin
      full = {1'b0, op_a} + {1'b0, op_b};
      sum = {8'h00, full[7:0]};
      carry = full[8];
      half = ({1'b0, op_a[3:0]} + {1'b0, op_b[3:0]}) > 5'h0f;
      ovf = (op_a[7] == op_b[7]) && (full[7] != op_a[7]);
   end
endmodule
`default_nettype wire

/* test/cfrsp_bench.sv */
// Self-checking bench of the flag register, working registers, pointers and stack pointer.
// Assumes the checker is bound by its own file and the ALU model drives the result ports.
`timescale 1ns/1ps
`default_nettype none
module cfrsp_bench;
   import cfrsp_pkg::*;
   typedef struct {int due; int k; logic [15:0] v;} cfrsp_note_t;
   localparam int K_F = 0, K_S = 1, K_A = 2, K_B = 3, K_P = 4, K_IO = 5, K_DS = 6, K_G = 7;
   logic clk_sys = 1'b0, rst_b = 1'b0, rd_wide = 1'b0, wr_en = 1'b0, wr_wide = 1'b0, use_alu = 1'b0;
   logic irq_req = 1'b0, io_req = 1'b0, io_we = 1'b0, ds_req = 1'b0, ds_we = 1'b0, alu_wide = 1'b0;
   logic irq_grant_q, ds_hit_q, io_hit_q;
   logic [4:0] rd_a_addr = 5'h00, rd_b_addr = 5'h00, wr_addr = 5'h00;
   logic [2:0] bit_sel = 3'h0;
   logic [5:0] io_addr = 6'h00, ptr_disp = 6'h05;
   logic [7:0] io_wdata = 8'h00, ds_wdata = 8'h00, alu_mask = 8'h3f, fx;
   logic [7:0] rd_a_data_q, rd_b_data_q, flag_q, ds_rdata_q, io_rdata_q;
   logic [15:0] wd = 16'h0000, ds_addr = 16'h0000, sp_q, ptr_addr_q, sp = 16'h08ff;
   logic [31:0] seed = 32'hb92f, r;
   logic [7:0] rm [32] = '{default: 8'h00};
   logic [7:0] pa [3] = '{8'h80, 8'h0f, 8'h00};
   logic [7:0] pb [3] = '{8'h80, 8'h01, 8'h00};
   logic [15:0] sdel [4] = '{16'hffff, 16'hfffe, 16'h0001, 16'h0002};
   logic [15:0] pexp [6] = '{16'h0110, 16'h0110, 16'h0110, 16'h0111, 16'h0110, 16'h0110};
   cfrsp_sp_op_t sops [4] = '{SP_PUSH1, SP_PUSH2, SP_POP1, SP_POP2};
   cfrsp_ptr_op_t pops [6] = '{PTR_PLAIN, PTR_DISP, PTR_POSTINC, PTR_PLAIN, PTR_PREDEC, PTR_PLAIN};
   cfrsp_ptr_sel_t psel [3] = '{PSEL_X, PSEL_Y, PSEL_Z};
   cfrsp_flag_op_t flag_op = FOP_NONE;
   cfrsp_sp_op_t sp_op = SP_HOLD;
   cfrsp_ptr_op_t ptr_op = PTR_NONE;
   cfrsp_ptr_sel_t ptr_sel = PSEL_X;
   cfrsp_note_t notes [$];
   int pcnt = 0, mismatches = 0, n_compared = 0;
   wire logic [15:0] alu_res;
   wire logic alu_c, alu_h, alu_v;
   wire logic [15:0] wr_data = use_alu ? alu_res : wd;
   wire logic [7:0][15:0] obs = {{15'h0000, irq_grant_q}, {7'h00, ds_hit_q, ds_rdata_q},
      {7'h00, io_hit_q, io_rdata_q}, ptr_addr_q, {8'h00, rd_b_data_q}, {8'h00, rd_a_data_q}, sp_q, {8'h00, flag_q}};
   cfrsp_top cfrsp_top_inst (.*);
   cfrsp_alu_model cfrsp_alu_model_inst (.op_a(rd_a_data_q), .op_b(rd_b_data_q), .sum(alu_res), .carry(alu_c),
      .half(alu_h), .ovf(alu_v));
   // Core clock of 40 ns and a count of its rising edges for the notes.
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) pcnt <= pcnt + 1;
   // Takes each note off the queue once its cycle has come and compares it.
   always @(negedge clk_sys) begin
      while (notes.size() > 0 && notes[0].due <= pcnt) begin
         n_compared++;
         if (obs[notes[0].k] !== notes[0].v) begin
            mismatches++;
            $display("[FAIL] %0t kind %0d got %h want %h", $time, notes[0].k, obs[notes[0].k], notes[0].v);
         end
         void'(notes.pop_front());
      end
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Expected flags of an eight-bit add with enable and copy bits clear.
   function automatic logic [7:0] fl(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      logic v;
      s = a + b;
      v = (a[7] == b[7]) && (s[7] != a[7]);
      return {2'b00, (a[3:0] + b[3:0]) > 5'h0f, s[7] ^ v, v, s[7], s[7:0] == 8'h00, s[8]};
   endfunction
   task automatic ex(input int k, input logic [15:0] v);
      notes.push_back('{pcnt + 1, k, v});
   endtask
   // Starts one cycle at the falling edge with the given strobes {write, io, data, irq}.
   task automatic cy(input cfrsp_flag_op_t f = FOP_NONE, input cfrsp_sp_op_t s = SP_HOLD,
                     input cfrsp_ptr_op_t p = PTR_NONE, input logic [3:0] st = 4'h0);
      @(negedge clk_sys);
      flag_op = f;
      sp_op = s;
      ptr_op = p;
      {wr_en, io_req, ds_req, irq_req} = st;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic w);
      cy(.st(4'h8));
      wr_addr = a;
      wd = d;
      wr_wide = w;
      use_alu = 1'b0;
      rm[a] = d[7:0];
      if (w) rm[a | 5'h01] = d[15:8];
   endtask
   task automatic rd(input logic [4:0] a, input logic w);
      cy();
      rd_wide = w;
      rd_a_addr = a;
      ex(K_A, {8'h00, rm[a]});
      if (w) ex(K_B, {8'h00, rm[a | 5'h01]});
   endtask
   task automatic io(input logic [5:0] a, input logic w, input logic [7:0] d);
      cy(.st(4'h4));
      io_addr = a;
      io_we = w;
      io_wdata = d;
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Cuts a hung run short and counts it as a failure.
   initial begin
      repeat (4000) @(posedge clk_sys);
      mismatches++;
      $display("[FAIL] %0t run did not finish", $time);
      tally_and_finish();
   end
   // Main sequence.
   initial begin
      repeat (12) @(negedge clk_sys);
      rst_b = 1'b1;
      cy();
      ex(K_F, 16'h0000);
      ex(K_S, TOP_OF_DATA_MEMORY);
      io(IO_SP_HIGH, 1'b1, 8'h08);
      io(IO_SP_LOW, 1'b1, 8'hff);
      io(IO_SP_HIGH, 1'b0, 8'h00);
      ex(K_IO, 16'h0108);
      io(6'h10, 1'b0, 8'h00);
      ex(K_IO, 16'h0000);
      foreach (sops[i]) begin
         cy(.s(sops[i]));
         sp = sp + sdel[i];
         ex(K_S, sp);
      end
      $display("stack pointer test done");
      cy(FOP_SEI);
      ex(K_F, 16'h0080);
      cy(.st(4'h1));
      ex(K_G, 16'h0001);
      ex(K_F, 16'h0000);
      cy(FOP_RETURN_FROM_INTERRUPT);
      ex(K_F, 16'h0080);
      cy(FOP_CLI, .st(4'h1));
      ex(K_G, 16'h0000);
      cy(.st(4'h1));
      ex(K_G, 16'h0000);
      $display("interrupt enable test done");
      r = xs();
      pa[2] = r[7:0];
      pb[2] = r[15:8];
      // Random enable and copy mask bits must never let the ALU touch those two flags.
      alu_mask = {r[31:30], 6'h3f};
      foreach (pa[i]) begin
         wr(5'd1, {8'h00, pa[i]}, 1'b0);
         wr(5'd2, {8'h00, pb[i]}, 1'b0);
         cy();
         rd_a_addr = 5'd1;
         rd_b_addr = 5'd2;
         cy(FOP_ALU, .st(4'h8));
         use_alu = 1'b1;
         wr_addr = 5'd3;
         fx = fl(pa[i], pb[i]);
         ex(K_F, {8'h00, fx});
         rm[3] = pa[i] + pb[i];
         rd(5'd3, 1'b0);
      end
      wr(5'd5, 16'h0040, 1'b0);
      cy();
      rd_a_addr = 5'd5;
      cy(FOP_BST);
      bit_sel = 3'd6;
      ex(K_F, {8'h00, fx | 8'h40});
      cy(FOP_BLD);
      bit_sel = 3'd0;
      wr_addr = 5'd6;
      rm[6] = 8'h41;
      rd(5'd6, 1'b0);
      $display("flag test done");
      wr(5'd26, 16'h0110, 1'b1);
      rd(5'd26, 1'b1);
      ptr_disp = r[21:16];
      foreach (pops[i]) begin
         cy(.p(pops[i]));
         ex(K_P, pexp[i] + ((pops[i] == PTR_DISP) ? 16'(ptr_disp) : 16'h0000));
      end
      foreach (psel[i]) begin
         r = xs();
         wr(5'(26 + 2 * i), r[15:0], 1'b1);
         cy(.p(PTR_PLAIN));
         ptr_sel = psel[i];
         ex(K_P, r[15:0]);
      end
      cy(.st(4'h2));
      ds_addr = 16'h0006;
      ex(K_DS, 16'h0141);
      cy(.st(4'h2));
      ds_addr = DS_REG_END;
      ex(K_DS, 16'h0000);
      // A data-space store into a register, seen at once on the data port and later on port a.
      cy(.st(4'h2));
      ds_we = 1'b1;
      ds_addr = 16'h0007;
      ds_wdata = r[23:16];
      rm[7] = r[23:16];
      ex(K_DS, {8'h01, r[23:16]});
      rd(5'd7, 1'b0);
      $display("pointer and data space test done");
      cy();
      cy();
      tally_and_finish();
   end
endmodule
`default_nettype wire
